// ---- rtl/hbcf_regs.vh ----
// Timing, threshold and interrupt-bit constants for the H-bridge control and fault logic
`ifndef HBCF_REGS_VH
`define HBCF_REGS_VH

`define HBCF_CLK_MHZ          200
`define HBCF_BLANK_NS         2000
`define HBCF_BLANK_CYC        ((`HBCF_BLANK_NS * `HBCF_CLK_MHZ + 999) / 1000)
`define HBCF_TOFF_NS          20000
`define HBCF_TOFF_CYC         ((`HBCF_TOFF_NS * `HBCF_CLK_MHZ + 999) / 1000)
`define HBCF_TEMP_W           8
`define HBCF_CUR_W            8
`define HBCF_TEMP_FOLD        8'hA0
`define HBCF_TEMP_SHUT        8'hAF
`define HBCF_TEMP_HYST        8'h0F
`define HBCF_ILIM_NORM        8'h41
`define HBCF_ILIM_FOLD        8'h2A
`define HBCF_ISC_THR          8'h82
`define HBCF_ADDR_STATUS      4'h0
`define HBCF_ADDR_MASK        4'h4
`define HBCF_ADDR_LEVEL       4'h8
`define HBCF_EV_SC            0
`define HBCF_EV_OT            1
`define HBCF_EV_LIM           2
`define HBCF_EV_FOLD          3
`define HBCF_EV_W             4
`define HBCF_MASK_RST         4'h0

`endif

// ---- rtl/hbcf_sync.v ----
// Two-flop synchroniser for one pin level with a chosen reset value
`timescale 1ns/10ps
`default_nettype none
module hbcf_sync #(
	parameter RST_VAL = 1'b0
) (
	input  wire clk,
	input  wire rst_n,
	input  wire pin_in,
	output wire level_out
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign level_out = sync_q;
endmodule
`default_nettype wire

// ---- rtl/hbcf_timer.v ----
// Loadable down-counter with a busy level, used for blanking and off time
`timescale 1ns/10ps
`default_nettype none
module hbcf_timer #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         start,
	input  wire [W-1:0] load_val,
	output wire         busy
);
	reg [W-1:0] cnt_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {W{1'b0}};
		end else if (start) begin
			cnt_q <= load_val;
		end else if (cnt_q != {W{1'b0}}) begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign busy = (cnt_q != {W{1'b0}});
endmodule
`default_nettype wire

// ---- rtl/hbcf_top.v ----
// H-bridge control, current regulation and fault latch-off logic
// What this block does
// - Each output follows only its own phase
// - Phase high drives supply, low drives ground
// - Disable high tri-states outputs, rest runs
// - Enable low tri-states outputs immediately
// - Enable low holds sleep with outputs off
// - Outputs operate only while enable high
// - Floating enable reads low, stays asleep
// - Floating disable and phase read high
// - Fault latch held until disable or enable toggles
// - Over limit: off for constant time
// - Hot junction lowers current limit threshold
// - Overtemperature latches outputs off, flags fault
// - Thermal shutdown detection has hysteresis
// - Short circuit latches outputs off, flags
// - Blanking timer restarts on output transitions
// - Open-drain active-low fault flag output
`include "hbcf_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module hbcf_top #(
	parameter integer BLANK_CYC = `HBCF_BLANK_CYC,
	parameter integer TOFF_CYC  = `HBCF_TOFF_CYC,
	parameter integer TW        = 16
) (
	input  wire                   clk,
	input  wire                   rst_n,
	input  wire                   phase_in_a,
	input  wire                   phase_in_b,
	input  wire                   phase_a_drv,
	input  wire                   phase_b_drv,
	input  wire                   disable_hi_in,
	input  wire                   disable_drv,
	input  wire                   enable_sleep_in,
	input  wire                   enable_drv,
	input  wire [`HBCF_TEMP_W-1:0] junction_temp,
	input  wire [`HBCF_CUR_W-1:0]  load_current,
	input  wire [3:0]             reg_addr,
	input  wire [31:0]            reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [31:0]            reg_rdata,
	output wire                   irq,
	output wire                   bridge_out_a,
	output wire                   bridge_out_a_oe,
	output wire                   bridge_out_b,
	output wire                   bridge_out_b_oe,
	output wire                   fault_flag_n,
	output wire                   fault_flag_n_oe,
	output wire                   sleep_mode,
	output wire [`HBCF_CUR_W-1:0]  current_limit_threshold
);
	localparam [TW-1:0] BLANK_LD = BLANK_CYC[TW-1:0];
	localparam [TW-1:0] TOFF_LD  = TOFF_CYC[TW-1:0];
	localparam [1:0] ST_RUN  = 2'b00;
	localparam [1:0] ST_OFF  = 2'b01;
	localparam [1:0] ST_LATCH = 2'b10;

	// Undriven pins resolve to their internal pull before sampling
	wire pa_raw  = phase_a_drv ? phase_in_a : 1'b1;
	wire pb_raw  = phase_b_drv ? phase_in_b : 1'b1;
	wire dis_raw = disable_drv ? disable_hi_in : 1'b1;
	wire en_raw  = enable_drv ? enable_sleep_in : 1'b0;

	// Reset levels match the pulls, so no false edge follows reset
	localparam [3:0] PIN_RST = 4'hE;
	wire [3:0] pin_raw = {pa_raw, pb_raw, dis_raw, en_raw};
	wire [3:0] pin_s;

	genvar si;
	generate
		for (si = 0; si < 4; si = si + 1) begin : g_sync
			hbcf_sync #(
				.RST_VAL (PIN_RST[si])
			) u_sync (
				.clk       (clk),
				.rst_n     (rst_n),
				.pin_in    (pin_raw[si]),
				.level_out (pin_s[si])
			);
		end
	endgenerate

	wire pa_s  = pin_s[3];
	wire pb_s  = pin_s[2];
	wire dis_s = pin_s[1];
	wire en_s  = pin_s[0];

	reg dis_prev_q;
	reg en_prev_q;
	reg pa_prev_q;
	reg pb_prev_q;
	reg sc_latch_q;
	reg ot_latch_q;
	reg ot_hot_q;
	reg [1:0] st_q;
	reg [1:0] st_d;
	reg [`HBCF_EV_W-1:0] status_q;
	reg [`HBCF_EV_W-1:0] mask_q;

	// A toggle on either the disable or the enable input clears the latches
	wire latch_clr = (dis_s != dis_prev_q) || (en_s != en_prev_q);
	wire any_latch = sc_latch_q | ot_latch_q;
	wire run_ok = en_s & ~dis_s & ~any_latch;

	// Thermal comparator with hysteresis so the shutdown does not chatter
	wire ot_set = (junction_temp > `HBCF_TEMP_SHUT);
	wire ot_rel = (junction_temp < (`HBCF_TEMP_SHUT - `HBCF_TEMP_HYST));
	wire fold   = (junction_temp >= `HBCF_TEMP_FOLD);

	// Threshold leaves on a flop, one cycle behind temperature
	reg [`HBCF_CUR_W-1:0] thr_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			thr_q <= `HBCF_ILIM_NORM;
		end else if (fold) begin
			thr_q <= `HBCF_ILIM_FOLD;
		end else begin
			thr_q <= `HBCF_ILIM_NORM;
		end
	end

	assign current_limit_threshold = thr_q;

	wire over_lim = (load_current > current_limit_threshold);
	wire short_i  = (load_current > `HBCF_ISC_THR);

	wire drive_on = run_ok & (st_q == ST_RUN);
	wire out_a_tr = drive_on & (pa_s != pa_prev_q);
	wire out_b_tr = drive_on & (pb_s != pb_prev_q);
	wire blank_start = out_a_tr | out_b_tr | (st_q == ST_OFF && st_d == ST_RUN);
	wire blank_busy;
	wire toff_busy;
	wire toff_start = (st_q == ST_RUN) && (st_d == ST_OFF);

	hbcf_timer #(.W(TW)) u_blank (
		.clk      (clk),
		.rst_n    (rst_n),
		.start    (blank_start),
		.load_val (BLANK_LD),
		.busy     (blank_busy)
	);
	hbcf_timer #(.W(TW)) u_toff (
		.clk      (clk),
		.rst_n    (rst_n),
		.start    (toff_start),
		.load_val (TOFF_LD),
		.busy     (toff_busy)
	);

	// A current still high once blanking ends is a short, not a load peak
	wire sc_detect = drive_on & short_i & ~blank_busy;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dis_prev_q <= 1'b1;
			en_prev_q  <= 1'b0;
			pa_prev_q  <= 1'b1;
			pb_prev_q  <= 1'b1;
		end else begin
			dis_prev_q <= dis_s;
			en_prev_q  <= en_s;
			pa_prev_q  <= pa_s;
			pb_prev_q  <= pb_s;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ot_hot_q <= 1'b0;
		end else if (ot_set) begin
			ot_hot_q <= 1'b1;
		end else if (ot_rel) begin
			ot_hot_q <= 1'b0;
		end
	end

	// A fresh fault wins over a toggle arriving in the same cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sc_latch_q <= 1'b0;
			ot_latch_q <= 1'b0;
		end else begin
			if (sc_detect) begin
				sc_latch_q <= 1'b1;
			end else if (latch_clr) begin
				sc_latch_q <= 1'b0;
			end
			if (ot_set && !ot_hot_q) begin
				ot_latch_q <= 1'b1;
			end else if (latch_clr) begin
				ot_latch_q <= 1'b0;
			end
		end
	end

	always @* begin
		st_d = st_q;
		case (st_q)
			ST_RUN: begin
				if (any_latch) begin
					st_d = ST_LATCH;
				end else if (run_ok && over_lim && !short_i) begin
					st_d = ST_OFF;
				end
			end
			ST_OFF: begin
				if (any_latch) begin
					st_d = ST_LATCH;
				end else if (!toff_busy) begin
					st_d = ST_RUN;
				end
			end
			ST_LATCH: begin
				if (!any_latch) begin
					st_d = ST_RUN;
				end
			end
			default: begin
				st_d = ST_RUN;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs gate off combinationally on enable or disable, no sequencing delay
	assign bridge_out_a    = pa_s;
	assign bridge_out_b    = pb_s;
	assign bridge_out_a_oe = drive_on;
	assign bridge_out_b_oe = drive_on;
	assign sleep_mode      = ~en_s;
	assign fault_flag_n    = 1'b0;
	assign fault_flag_n_oe = any_latch;

	// Interrupt status: sticky, write one to clear, set beats clear
	wire [`HBCF_EV_W-1:0] ev;
	assign ev[`HBCF_EV_SC]   = sc_detect & ~sc_latch_q;
	assign ev[`HBCF_EV_OT]   = ot_set & ~ot_hot_q;
	assign ev[`HBCF_EV_LIM]  = toff_start;
	assign ev[`HBCF_EV_FOLD] = fold;

	function addr_is;
		input [3:0] a;
		input [3:0] ref_a;
		begin
			addr_is = (a == ref_a);
		end
	endfunction

	wire wr_status = reg_wr && addr_is(reg_addr, `HBCF_ADDR_STATUS);
	wire wr_mask   = reg_wr && addr_is(reg_addr, `HBCF_ADDR_MASK);

	genvar gi;
	generate
		for (gi = 0; gi < `HBCF_EV_W; gi = gi + 1) begin : g_stat
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					status_q[gi] <= 1'b0;
				end else if (ev[gi]) begin
					status_q[gi] <= 1'b1;
				end else if (wr_status && reg_wdata[gi]) begin
					status_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= `HBCF_MASK_RST;
		end else if (wr_mask) begin
			mask_q <= reg_wdata[`HBCF_EV_W-1:0];
		end
	end

	assign irq = |(status_q & mask_q);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else if (addr_is(reg_addr, `HBCF_ADDR_STATUS)) begin
			reg_rdata <= {28'h0000000, status_q};
		end else if (addr_is(reg_addr, `HBCF_ADDR_MASK)) begin
			reg_rdata <= {28'h0000000, mask_q};
		end else if (addr_is(reg_addr, `HBCF_ADDR_LEVEL)) begin
			reg_rdata <= {24'h000000, ot_hot_q, ~en_s, dis_s, st_q, ot_latch_q,
				sc_latch_q, drive_on};
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// ---- sim/hbcf_checker.sv ----
// Concurrent checks on the H-bridge control and fault logic ports
`timescale 1ns/10ps
`default_nettype none
`include "hbcf_regs.vh"
module hbcf_checker (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire logic                    disable_hi_in,
	input wire logic                    disable_drv,
	input wire logic                    enable_sleep_in,
	input wire logic                    enable_drv,
	input wire logic [`HBCF_TEMP_W-1:0] junction_temp,
	input wire logic [3:0]              reg_addr,
	input wire logic                    reg_rd,
	input wire logic [31:0]             reg_rdata,
	input wire logic                    bridge_out_a_oe,
	input wire logic                    bridge_out_b_oe,
	input wire logic                    fault_flag_n,
	input wire logic                    fault_flag_n_oe,
	input wire logic                    sleep_mode,
	input wire logic [`HBCF_CUR_W-1:0]  current_limit_threshold
);
	// Pin levels as the device sees them, released pins at their pull level
	wire en_eff  = enable_drv & enable_sleep_in;
	wire dis_eff = disable_hi_in | ~disable_drv;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_oe_pair; bridge_out_a_oe == bridge_out_b_oe; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("outputs enabled apart");
	property p_flag_low; !fault_flag_n; endproperty
	a_flag_low: assert property (p_flag_low) else $error("flag pin drives high");
	property p_fault_off; fault_flag_n_oe |-> !bridge_out_a_oe; endproperty
	a_fault_off: assert property (p_fault_off) else $error("drive during fault");
	property p_en_off; !en_eff [*2] |=> !bridge_out_a_oe && sleep_mode; endproperty
	a_en_off: assert property (p_en_off) else $error("enable low not off");
	property p_sleep; sleep_mode |-> !bridge_out_b_oe; endproperty
	a_sleep: assert property (p_sleep) else $error("drive while asleep");
	property p_dis_off; dis_eff [*2] |=> !bridge_out_b_oe; endproperty
	a_dis_off: assert property (p_dis_off) else $error("disable high not off");
	property p_fold;
		junction_temp >= `HBCF_TEMP_FOLD [*3] |-> current_limit_threshold == `HBCF_ILIM_FOLD;
	endproperty
	a_fold: assert property (p_fold) else $error("limit not folded");
	property p_norm;
		junction_temp < `HBCF_TEMP_FOLD [*3] |-> current_limit_threshold == `HBCF_ILIM_NORM;
	endproperty
	a_norm: assert property (p_norm) else $error("limit not normal");
	property p_level;
		reg_rd && reg_addr == `HBCF_ADDR_LEVEL |=> (reg_rdata[1] | reg_rdata[2]) == $past(fault_flag_n_oe);
	endproperty
	a_level: assert property (p_level) else $error("latch bits disagree with flag");
	c_fault: cover property (fault_flag_n_oe);
	c_fold: cover property (current_limit_threshold == `HBCF_ILIM_FOLD);
	c_on: cover property (bridge_out_a_oe);
endmodule
bind hbcf_top hbcf_checker i_chk (.clk, .rst_n, .disable_hi_in, .disable_drv, .enable_sleep_in,
	.enable_drv, .junction_temp, .reg_addr, .reg_rd, .reg_rdata, .bridge_out_a_oe,
	.bridge_out_b_oe, .fault_flag_n, .fault_flag_n_oe, .sleep_mode, .current_limit_threshold);
`default_nettype wire

// ---- sim/hbcf_host.sv ----
// Host pin model: phase a, phase b, disable, enable with drive or release
`timescale 1ns/10ps
`default_nettype none
module hbcf_host (
	input  wire logic       clk,
	output wire logic [3:0] pin,
	output wire logic [3:0] drv
);
	logic [3:0] val_q = 4'h0;
	logic [3:0] drv_q = 4'h0;
	// Released pins rest at their pull level: up for phase and disable, down for enable
	assign pin = (val_q & drv_q) | (4'hE & ~drv_q);
	assign drv = drv_q;
	// Pins change only at calls spaced far closer than an 11 kHz PWM period
	task set(input logic [3:0] v, input logic [3:0] d);
		@(posedge clk);
		val_q <= v;
		drv_q <= d;
	endtask
endmodule
`default_nettype wire

// ---- sim/hbcf_top_tb.sv ----
// Self-checking bench for the H-bridge control and fault logic
`timescale 1ns/10ps
`default_nettype none
`include "hbcf_regs.vh"
module hbcf_top_tb;
	logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, rdata;
	logic [7:0]  temp = 8'h00, cur = 8'h00;
	wire  [3:0]  pin, drv;
	wire  [31:0] reg_rdata;
	wire  [7:0]  thr;
	wire         irq, oa, ooe, ob, boe, ff, ffoe, slp;
	int          err_total = 0, n_checks = 0, cyc = 0;
	always #2.5 clk = ~clk;
	hbcf_host i_host (.clk(clk), .pin(pin), .drv(drv));
	// Short timer values keep the run brief
	hbcf_top #(.BLANK_CYC(4), .TOFF_CYC(8)) i_dut (.clk(clk), .rst_n(rst_n),
		.phase_in_a(pin[3]), .phase_in_b(pin[2]), .phase_a_drv(drv[3]), .phase_b_drv(drv[2]),
		.disable_hi_in(pin[1]), .disable_drv(drv[1]), .enable_sleep_in(pin[0]),
		.enable_drv(drv[0]), .junction_temp(temp), .load_current(cur), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .bridge_out_a(oa), .bridge_out_a_oe(ooe), .bridge_out_b(ob),
		.bridge_out_b_oe(boe), .fault_flag_n(ff), .fault_flag_n_oe(ffoe), .sleep_mode(slp),
		.current_limit_threshold(thr));
	task print_verdict;
		if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(nm, reg_rdata, e);
	endtask
	task pins(input logic [3:0] v, input int n);
		i_host.set(v, 4'hF);
		wt(n);
	endtask
	// A hang counts against the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			print_verdict;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wt(3);
		chk("float en", {slp, ooe, boe}, 3'b100);
		i_host.set(4'b0001, 4'b0001); wt(4);
		chk("float dis", {slp, ooe, boe}, 3'b000);
		i_host.set(4'b0001, 4'b0011); wt(4);
		chk("float phase", {ooe, boe, oa, ob}, 4'hF);
		for (int i = 0; i < 4; i++) begin
			pins({i[1:0], 2'b01}, 4);
			chk("phase", {ooe, boe, oa, ob}, {2'b11, i[1:0]});
		end
		pins(4'b1011, 4);
		chk("disable", {slp, ooe, boe}, 3'b000);
		pins(4'b1001, 10);
		@(posedge clk) cur <= 8'h50;
		wt(2); chk("limit off", ooe, 1'b0);
		@(posedge clk) cur <= 8'h10;
		wt(12); chk("limit on", ooe, 1'b1);
		rdc("status", `HBCF_ADDR_STATUS, 32'h4);
		chk("irq masked", irq, 1'b0);
		wr(`HBCF_ADDR_MASK, 32'h4); wt(1); chk("irq", irq, 1'b1);
		wr(`HBCF_ADDR_STATUS, 32'h4); wt(1); chk("irq clear", irq, 1'b0);
		rdc("unmapped", 4'hC, 32'h0);
		@(posedge clk) cur <= 8'h90;
		wt(2); chk("short", {ffoe, ff, ooe}, 3'b100);
		@(posedge clk) cur <= 8'h10;
		wt(6); chk("held", {ffoe, ooe}, 2'b10);
		rdc("level", `HBCF_ADDR_LEVEL, 32'h12);
		pins(4'b1011, 3); pins(4'b1001, 4);
		chk("cleared", {ffoe, ooe}, 2'b01);
		@(posedge clk) temp <= 8'hA0;
		wt(4); chk("fold", thr, 8'h2A);
		@(posedge clk) temp <= 8'hB0;
		wt(3); chk("overtemp", {ffoe, ooe}, 2'b10);
		@(posedge clk) temp <= 8'hA5;
		pins(4'b1000, 3); chk("sleep", slp, 1'b1);
		pins(4'b1001, 4);
		@(posedge clk) temp <= 8'hB0;
		wt(3); chk("no retrip", ffoe, 1'b0);
		@(posedge clk) temp <= 8'h90;
		wt(4); chk("normal", thr, 8'h41);
		@(posedge clk) temp <= 8'hB0;
		wt(3); chk("retrip", ffoe, 1'b1);
		rdc("status all", `HBCF_ADDR_STATUS, 32'hB);
		print_verdict;
	end
endmodule
`default_nettype wire
